// File: design/afp_defs.vh
/*
 fault-protection and reporting constants.
 assumes inclusion by bare name from design files.
*/
`ifndef AFP_DEFS_VH
`define AFP_DEFS_VH
// output configuration codes
`define AFP_CFG_BRIDGED     2'h0
`define AFP_CFG_PARALLELED  2'h1
`define AFP_CFG_SINGLE      2'h2
// apb register byte offsets
`define AFP_OFF_CTRL        12'h000
`define AFP_OFF_STATUS      12'h004
`define AFP_OFF_PINS        12'h008
// ctrl field positions and reset value
`define AFP_CTRL_CFG_LSB    0
`define AFP_CTRL_CFG_MSB    1
`define AFP_CTRL_RESET      32'h00000000
// status field positions
`define AFP_ST_UV           0
`define AFP_ST_OL_LATCH     1
`define AFP_ST_OTE_LATCH    2
`define AFP_ST_WARN_LO      3
`define AFP_ST_WARN_HI      4
`define AFP_ST_BST_LSB      5
`define AFP_ST_HIZ_LSB      9
// host reset spacing after shutdown falls
`define AFP_RST_HOLD_MS     4
`define AFP_CLK_HZ          25000000
`define AFP_RST_HOLD_CYC    ((`AFP_RST_HOLD_MS * `AFP_CLK_HZ) / 1000)
`endif

// File: design/afp_sync.v
/*
 two-flop synchroniser, vector wide.
 assumes async level inputs; first stage read only by second.
*/
`timescale 1ns/1ps
module afp_sync #(
    parameter W = 1
) (
    // clock and reset
    input  wire         mclk,
    input  wire         rst_b,
    input  wire         clk_en,
    // data
    input  wire [W-1:0] d_async,
    output reg  [W-1:0] q_sync
);
    reg [W-1:0] meta_reg;
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= {W{1'b0}};
            q_sync   <= {W{1'b0}};
        end else if (clk_en) begin
            meta_reg <= d_async;
            q_sync   <= meta_reg;
        end
    end
endmodule // afp_sync

// File: design/afp_apb.v
/*
 apb slave register file: ctrl (rw), status and pins (ro).
 assumes apb master on mclk; zero wait states.
*/
`timescale 1ns/1ps
`include "afp_defs.vh"
module afp_apb (
    // clock and reset
    input  wire        mclk,
    input  wire        rst_b,
    input  wire        clk_en,
    // apb
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // block side
    output reg  [1:0]  cfg,
    input  wire [31:0] status_word,
    input  wire [31:0] pins_word
);
    wire setup = psel && !penable;
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cfg     <= `AFP_CFG_BRIDGED;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end else if (clk_en) begin
            // ready from a flop: high only in the access cycle after setup
            pready <= setup;
            if (setup) begin
                pslverr <= 1'b0;
                prdata  <= 32'h00000000;
                case (paddr)
                    `AFP_OFF_CTRL: begin
                        prdata <= {30'h0, cfg};
                    end
                    `AFP_OFF_STATUS: begin
                        prdata <= status_word;
                    end
                    `AFP_OFF_PINS: begin
                        prdata <= pins_word;
                    end
                    default: begin
                        pslverr <= 1'b1;
                    end
                endcase
            end else if (psel && penable && pwrite && paddr == `AFP_OFF_CTRL) begin
                cfg <= pwdata[`AFP_CTRL_CFG_MSB:`AFP_CTRL_CFG_LSB];
            end
        end
    end
endmodule // afp_apb

// File: design/afp_top.v
/*
 fault protection and status reporting for a four half-bridge stage.
 assumes comparator flags are async levels; amp_reset_n is the device
 reset pin (async, sampled); rst_b is power-on reset.
*/
// Functional notes
// R1 - bridges hi-z until both supplies good
// R2 - reset low enables weak bootstrap pulldown
// R3 - fully operational while supplies stay good
// R4 - host holds reset low at power-down
// R5 - indicators active-low open-drain outputs
// R6 - shutdown indicator low on any fault
// R7 - warnings low above 125 and 100 degrees
// R8 - cause encoded on warnings during shutdown
// R9 - warnings show temperature when not shut down
// R10 - reset low forces shutdown indicator high
// R11 - host monitors warning, reduces volume
// R12 - fault immediately hi-z plus shutdown low
// R13 - other faults recover automatically when cleared
// R14 - fault domain mapping by output configuration
// R15 - bootstrap undervoltage stops only its bridge
// R16 - any supply ordering, power-on reset initialises
// R17 - overtemperature error latched until reset
// R18 - overload cleared only on reset rising edge
// R19 - host waits 4 ms before raising reset
// R20 - single-ended: hi-z without pulldown in reset
// R21 - comparator inputs synchronised before use
`timescale 1ns/1ps
`include "afp_defs.vh"
module afp_top (
    // clock and reset
    input  wire        mclk,
    input  wire        rst_b,
    input  wire        clk_en,
    // apb
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // device pins and comparators (async)
    input  wire        amp_reset_n,
    input  wire        gate_drive_supply_uv,
    input  wire        common_supply_uv,
    input  wire [3:0]  bootstrap_node_uv,
    input  wire [3:0]  overload_fault,
    input  wire        temp_over_100,
    input  wire        temp_over_125,
    input  wire        overtemp_error,
    // half-bridge control
    output reg  [3:0]  bridge_enable,
    output reg  [3:0]  bridge_pulldown,
    // open-drain indicators: out always 0, oe pulls low
    output reg         shutdown_indicator_n_out,
    output reg         shutdown_indicator_n_oe,
    output reg         temp_warning_n_out,
    output reg         temp_warning_n_oe,
    output reg         temp_warning_low_level_n_out,
    output reg         temp_warning_low_level_n_oe,
    output reg         temp_warning_high_level_n_out,
    output reg         temp_warning_high_level_n_oe
);
    wire [1:0] cfg;
    wire [13:0] s;
    // R21
    afp_sync #(.W(14)) u_sync (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .d_async ({amp_reset_n, gate_drive_supply_uv, common_supply_uv, bootstrap_node_uv,
                   overload_fault, temp_over_100, temp_over_125, overtemp_error}),
        .q_sync  (s)
    );
    wire       rst_pin_n = s[13];
    wire       uv_any    = s[12] | s[11];
    wire [3:0] bst_uv    = s[10:7];
    wire [3:0] ol_in     = s[6:3];
    wire       t100      = s[2] | s[1];
    wire       t125      = s[1];
    wire       ote_in    = s[0];

    // fault domain mapping; also used for the latched overload
    function [3:0] domain_map;
        input [1:0] c;
        input [3:0] e;
        begin
            if (c == `AFP_CFG_PARALLELED)
                domain_map = {4{|e}}; // R14
            else
                domain_map = {{2{|e[3:2]}}, {2{|e[1:0]}}}; // R14
        end
    endfunction

    reg        rst_pin_d_reg;
    reg [3:0]  ol_latch_reg;
    reg        ote_latch_reg;
    reg [3:0]  ol_latch_next;
    reg        ote_latch_next;
    // edge of sampled pin; powers up as held low so por acts like reset
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            rst_pin_d_reg <= 1'b0; // R16
        else if (clk_en)
            rst_pin_d_reg <= rst_pin_n;
    end
    wire rst_rise = rst_pin_n && !rst_pin_d_reg;

    always @* begin
        ol_latch_next  = ol_latch_reg;
        ote_latch_next = ote_latch_reg;
        if (!rst_pin_n)
            ote_latch_next = 1'b0; // R17
        else if (ote_in)
            ote_latch_next = 1'b1; // R17
        if (rst_rise)
            ol_latch_next = ol_in; // R18
        else if (rst_pin_n)
            ol_latch_next = ol_latch_reg | ol_in; // R18
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ol_latch_reg  <= 4'h0; // R16
            ote_latch_reg <= 1'b0;
        end else if (clk_en) begin
            ol_latch_reg  <= ol_latch_next;
            ote_latch_reg <= ote_latch_next;
        end
    end

    // combinational protection view; overload and ote act at once
    // old latch ignored on the release edge, else shutdown glitches low
    wire [3:0] ol_now  = (rst_rise ? 4'h0 : ol_latch_reg) | ol_in; // R18
    wire       ote_now = ote_latch_reg | ote_in;
    wire [3:0] off_dom = domain_map(cfg, ol_now) | {4{ote_now | uv_any}}; // R1 R13 R14
    wire [3:0] off_all = off_dom | bst_uv; // R15
    wire       fault   = |off_all; // R6
    wire       se_cfg  = (cfg == `AFP_CFG_SINGLE);

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bridge_enable                 <= 4'h0;
            bridge_pulldown               <= 4'h0;
            shutdown_indicator_n_out      <= 1'b0;
            shutdown_indicator_n_oe       <= 1'b0;
            temp_warning_n_out            <= 1'b0;
            temp_warning_n_oe             <= 1'b0;
            temp_warning_low_level_n_out  <= 1'b0;
            temp_warning_low_level_n_oe   <= 1'b0;
            temp_warning_high_level_n_out <= 1'b0;
            temp_warning_high_level_n_oe  <= 1'b0;
        end else if (clk_en) begin
            if (!rst_pin_n) begin
                bridge_enable   <= 4'h0; // R2
                bridge_pulldown <= se_cfg ? 4'h0 : 4'hf; // R2 R20
            end else begin
                bridge_enable   <= ~off_all; // R3 R12
                bridge_pulldown <= 4'h0;
            end
            // shutdown low on fault, forced high while pin reset
            shutdown_indicator_n_oe <= rst_pin_n && fault; // R5 R6 R10 R12
            // ote during shutdown pulls all warnings low
            temp_warning_low_level_n_oe  <= t100 | (fault && ote_now); // R7 R8 R9
            temp_warning_high_level_n_oe <= t125 | (fault && ote_now); // R7 R8 R9
            temp_warning_n_oe            <= t125 | (fault && ote_now); // R7 R8 R9
        end
    end

    wire [31:0] status_word = {19'h0, bridge_enable, bst_uv, t125, t100,
                               ote_latch_reg, |ol_latch_reg, uv_any};
    wire [31:0] pins_word   = {28'h0, temp_warning_n_oe, temp_warning_high_level_n_oe,
                               temp_warning_low_level_n_oe, shutdown_indicator_n_oe};

    afp_apb u_apb (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .clk_en      (clk_en),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .prdata      (prdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .cfg         (cfg),
        .status_word (status_word),
        .pins_word   (pins_word)
    );
endmodule // afp_top

// File: tb/afp_assertions.sv
/* afp_chk: protection assertions on the afp_top pins.
   assumes a bench that holds inputs steady; checks paused while clk_en is low. */
`timescale 1ns/1ps
module afp_chk (
    // clock and reset
    input wire       mclk,
    input wire       rst_b,
    input wire       clk_en,
    // reset pin and comparators
    input wire       amp_reset_n,
    input wire       gate_drive_supply_uv,
    input wire       common_supply_uv,
    input wire [3:0] bootstrap_node_uv,
    input wire [3:0] overload_fault,
    input wire       temp_over_100,
    input wire       temp_over_125,
    input wire       overtemp_error,
    // outputs
    input wire [3:0] bridge_enable,
    input wire       shutdown_indicator_n_oe,
    input wire       temp_warning_n_oe,
    input wire       temp_warning_low_level_n_oe,
    input wire       temp_warning_high_level_n_oe
);
    // four samples span two sync flops plus the output register
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b || !clk_en);
    pin_reset_a: assert property ((!amp_reset_n)[*4] |-> !shutdown_indicator_n_oe && bridge_enable == 4'h0)
        else $error("pin reset not honoured");
    uv_hiz_a: assert property ((amp_reset_n && (gate_drive_supply_uv || common_supply_uv))[*4]
        |-> bridge_enable == 4'h0 && shutdown_indicator_n_oe) else $error("supply fault not handled");
    warn_high_a: assert property (temp_over_125[*4] |-> temp_warning_high_level_n_oe && temp_warning_n_oe)
        else $error("high warning missing");
    warn_low_a: assert property ((temp_over_100 || temp_over_125)[*4] |-> temp_warning_low_level_n_oe)
        else $error("low warning missing");
    // eight samples leave room for a latched error to clear first
    warn_off_a: assert property ((!temp_over_100 && !temp_over_125 && !overtemp_error)[*8]
        |-> !temp_warning_high_level_n_oe && !temp_warning_low_level_n_oe) else $error("warning stuck");
    bst_one_a: assert property ((bootstrap_node_uv != 4'h0 && $stable(bootstrap_node_uv))[*4]
        |-> (bridge_enable & bootstrap_node_uv) == 4'h0) else $error("bootstrap bridge on");
    ol_latch_a: assert property ((amp_reset_n && overload_fault != 4'h0)[*4] ##1 amp_reset_n[*4]
        |-> shutdown_indicator_n_oe) else $error("overload not latched");
    ote_latch_a: assert property ((amp_reset_n && overtemp_error)[*4] ##1 amp_reset_n[*4]
        |-> bridge_enable == 4'h0 && shutdown_indicator_n_oe) else $error("overtemp not latched");
    cover property (amp_reset_n && overload_fault != 4'h0);
    cover property (amp_reset_n && overtemp_error);
    cover property ($rose(amp_reset_n));
endmodule // afp_chk
bind afp_top afp_chk i_chk (.*);

// File: tb/afp_host.sv
/* afp_host: host model pulling up the status pins and driving the reset pin.
   assumes oe high pulls a pin low; HOLD counts mclk cycles. */
`timescale 1ns/1ps
module afp_host #(
    parameter HOLD = 100000
) (
    // clock
    input  wire       mclk,
    // open-drain pulls from the device
    input  wire       shutdown_indicator_n_oe,
    input  wire       temp_warning_n_oe,
    input  wire       temp_warning_low_level_n_oe,
    input  wire       temp_warning_high_level_n_oe,
    // host side
    input  wire       rst_req,
    output wire [3:0] ind_n,
    output reg        amp_reset_n
);
    integer gap = HOLD;
    reg     shut_q = 1'b0;
    // pull-ups: a released pin reads high
    assign ind_n = ~{shutdown_indicator_n_oe, temp_warning_low_level_n_oe,
                     temp_warning_high_level_n_oe, temp_warning_n_oe};
    initial amp_reset_n = 1'b0;
    // pin may rise only once HOLD has passed since shutdown fell
    always @(posedge mclk) begin
        shut_q <= shutdown_indicator_n_oe;
        if (shutdown_indicator_n_oe && !shut_q)
            gap <= 0;
        else if (gap < HOLD)
            gap <= gap + 1;
        // only a rise waits for the hold; lowering is always allowed
        amp_reset_n <= amp_reset_n ? !rst_req : (!rst_req && gap >= HOLD);
    end
endmodule // afp_host

// File: tb/amp_fault_protection_reporting_bench.sv
/* bench for afp_top: apb master, host model, expectation queue.
   assumes 25 MHz mclk and zero-wait apb. */
`timescale 1ns/1ps
`define CHK(e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value at %0t: %h %h", $time, e, g); end end
module amp_fault_protection_reporting_bench;
    reg          mclk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg  [11:0]  paddr = 12'h0;
    reg  [31:0]  pwdata = 32'h0;
    reg          gate_drive_supply_uv = 1'b1, common_supply_uv = 1'b1, rst_req = 1'b1, look = 1'b0;
    reg          temp_over_100 = 1'b0, temp_over_125 = 1'b0, overtemp_error = 1'b0;
    reg  [3:0]   bootstrap_node_uv = 4'h0, overload_fault = 4'h0, ind[6] = '{4'hf, 4'hb, 4'h8, 4'h7, 4'h3, 4'h0};
    wire [31:0]  prdata;
    wire         pready, pslverr, amp_reset_n, shutdown_indicator_n_oe, temp_warning_n_oe;
    wire         temp_warning_low_level_n_oe, temp_warning_high_level_n_oe;
    wire [3:0]   bridge_enable, bridge_pulldown, ind_n;
    logic [32:0] ev, mv, exp_q[$], msk_q[$];
    int          num_errors = 0, n_compared = 0;
    afp_top i_dut (.*, .shutdown_indicator_n_out(), .temp_warning_n_out(), .temp_warning_low_level_n_out(),
        .temp_warning_high_level_n_out());
    afp_host #(.HOLD(8)) i_host (.*);
    initial forever #20 mclk = ~mclk;
    always @(posedge mclk) begin
        if (look || (psel && penable && pready && !pwrite)) begin
            ev = exp_q.pop_front();
            mv = msk_q.pop_front();
            `CHK(ev, mv & (look ? {21'h0, bridge_enable, bridge_pulldown, ind_n} : {pslverr, prdata}))
        end
    end
    task give_verdict;
        begin
            if (num_errors == 0 && n_compared > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge mclk);
            penable <= 1'b1;
            n = 0;
            do begin @(posedge mclk); n++; end while (!pready && n < 20);
            if (!pready) begin num_errors++; give_verdict(); end
            psel <= 1'b0;
            penable <= 1'b0;
            // one idle edge so a following call never re-drives psel in this step
            @(posedge mclk);
        end
    endtask
    task rd(input logic [11:0] a, input logic [32:0] e);
        begin
            exp_q.push_back(e);
            msk_q.push_back({33{1'b1}});
            apb(1'b0, a, 32'h0);
        end
    endtask
    // six edges: host flop, two sync flops, output register, margin
    task pins(input logic [11:0] e, input logic [11:0] m);
        begin
            repeat (6) @(posedge mclk);
            exp_q.push_back({21'h0, e});
            msk_q.push_back({21'h0, m});
            look <= 1'b1;
            @(posedge mclk);
            look <= 1'b0;
        end
    endtask
    initial begin
        repeat (50000) @(posedge mclk);
        num_errors++;
        give_verdict();
    end
    initial begin
        int b;
        logic [3:0] dom;
        void'($urandom(32'h298aa1cb));
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        pins(12'h0ff, 12'hfff);
        gate_drive_supply_uv <= 1'b0;
        rst_req <= 1'b0;
        pins(12'h007, 12'hfff);
        common_supply_uv <= 1'b0;
        pins(12'hf0f, 12'hfff);
        rd(12'h004, 33'h1e00);
        apb(1'b1, 12'h00c, $urandom);
        rd(12'h00c, 33'h100000000);
        for (int c = 0; c < 4; c++) begin
            b = $urandom % 4;
            dom = (c == 1) ? 4'hf : (b < 2 ? 4'h3 : 4'hc);
            apb(1'b1, 12'h000, 32'(c));
            rd(12'h000, 33'(c));
            overload_fault <= 4'h1 << b;
            pins({4'hf & ~dom, 8'h07}, 12'hfff);
            overload_fault <= 4'h0;
            pins({4'hf & ~dom, 8'h07}, 12'hfff);
            rst_req <= 1'b1;
            pins({4'h0, c == 2 ? 4'h0 : 4'hf, 4'hf}, 12'hfff);
            rst_req <= 1'b0;
            pins(12'hf0f, 12'hfff);
        end
        for (int i = 0; i < 6; i++) begin
            common_supply_uv <= (i >= 3);
            temp_over_100 <= (i % 3 != 0);
            temp_over_125 <= (i % 3 == 2);
            pins({i >= 3 ? 4'h0 : 4'hf, 4'h0, ind[i]}, 12'hfff);
        end
        common_supply_uv <= 1'b0;
        overtemp_error <= 1'b1;
        pins(12'h000, 12'hfff);
        overtemp_error <= 1'b0;
        pins(12'h000, 12'hfff);
        temp_over_100 <= 1'b0;
        temp_over_125 <= 1'b0;
        rst_req <= 1'b1;
        pins(12'h0ff, 12'hfff);
        rst_req <= 1'b0;
        pins(12'hf0f, 12'hfff);
        b = $urandom % 4;
        bootstrap_node_uv <= 4'h1 << b;
        pins({4'hf & ~(4'h1 << b), 8'h07}, 12'hfff);
        bootstrap_node_uv <= 4'h0;
        pins(12'hf0f, 12'hfff);
        // a fault that comes and goes while frozen must leave no trace
        clk_en <= 1'b0;
        common_supply_uv <= 1'b1;
        pins(12'hf0f, 12'hfff);
        common_supply_uv <= 1'b0;
        pins(12'hf0f, 12'hfff);
        clk_en <= 1'b1;
        pins(12'hf0f, 12'hfff);
        give_verdict();
    end
endmodule // amp_fault_protection_reporting_bench
